/* File: core/amp_i2c_slave.sv */
// Chosen here: the register offsets and the two-wire serial interface to the registers.
`timescale 1ns/1ns
module amp_i2c_slave
  import amp_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  amp_if.dev bus,
  input wire logic ocsd,
  input wire logic uv,
  input wire logic ov,
  input wire logic dc_det,
  input wire logic otsd,
  input wire logic diag_short,
  input wire logic short_pvdd,
  input wire logic short_gnd,
  input wire logic open_load,
  input wire logic shorted_load,
  input wire logic diag_busy,
  output logic [1:0] gain_code,
  output logic [2:0] limiter_code,
  output logic freq_sel,
  output logic out_run,
  output logic out_hiz
);
  // ************************************************
  // Pin synchronisers and bus conditions
  // ************************************************
  logic [2:0] scl_sy_ff;
  logic [2:0] sda_sy_ff;
  logic [1:0] stby_sy_ff;
  logic [1:0] mute_sy_ff;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, protect;
  // Two flops per pin, third stage for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
      stby_sy_ff <= 2'h0;
      mute_sy_ff <= 2'h0;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], bus.scl};
      sda_sy_ff <= {sda_sy_ff[1:0], bus.sda};
      stby_sy_ff <= {stby_sy_ff[0], bus.standby_n};
      mute_sy_ff <= {mute_sy_ff[0], bus.mute};
    end
  end

  assign scl_s = scl_sy_ff[1];
  assign sda_s = sda_sy_ff[1];
  assign scl_rise = scl_s & ~scl_sy_ff[2];
  assign scl_fall = ~scl_s & scl_sy_ff[2];
  assign start_det = scl_s & scl_sy_ff[2] & sda_sy_ff[2] & ~sda_s;
  assign stop_det = scl_s & scl_sy_ff[2] & ~sda_sy_ff[2] & sda_s;
  assign protect = ocsd | uv | ov | dc_det | otsd | diag_short;
  // ************************************************
  // Wake-up delay after standby release
  // ************************************************
  logic [31:0] wake_cnt_ff;
  logic bus_en_ff;
  // Count from standby release to bus enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_ff <= 32'h0;
      bus_en_ff <= 1'b0;
    end else if (!stby_sy_ff[1]) begin
      wake_cnt_ff <= 32'h0;
      bus_en_ff <= 1'b0;
    end else if (!bus_en_ff) begin
      if (wake_cnt_ff >= 32'(WAKE_CYC - 1)) begin
        bus_en_ff <= 1'b1;
      end else begin
        wake_cnt_ff <= wake_cnt_ff + 32'h1;
      end
    end
  end
  // ************************************************
  // Operating mode and fault pin
  // ************************************************
  logic run_ff, hiz_ff, fault_oe_n_ff;
  // Play only when awake, unmuted and fault free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= 1'b0;
      hiz_ff <= 1'b1;
      fault_oe_n_ff <= 1'b1;
    end else begin
      run_ff <= stby_sy_ff[1] & ~mute_sy_ff[1] & ~protect & ~diag_busy;
      hiz_ff <= ~stby_sy_ff[1] | mute_sy_ff[1] | protect | diag_busy;
      fault_oe_n_ff <= ~(stby_sy_ff[1] & protect);
    end
  end
  // ************************************************
  // Registers
  // ************************************************
  dev_state_t st_ff, ack_next_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff, tx_ff, idx_ff, fault_ff, status_ff, ctrl_ff, rd_val, fault_set;
  logic mack_ff, sda_oe_n_ff, load_now, wr_now;
  // Register read mux by index
  function automatic logic [7:0] rd_reg(input logic [7:0] idx, input logic [7:0] f,
                                        input logic [7:0] s, input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_FAULT) begin
      v = f;
    end else if (idx == IDX_STATUS) begin
      v = s;
    end else if (idx == IDX_CTRL) begin
      v = c;
    end
    return v;
  endfunction
  // Read data and bus strobes
  assign rd_val = rd_reg(idx_ff, fault_ff, status_ff, ctrl_ff);
  assign load_now = bus_en_ff & scl_fall & ~start_det & ~stop_det &
                    (((st_ff == S_ACK) & (ack_next_ff == S_RDATA)) |
                     ((st_ff == S_RACK) & mack_ff));
  assign wr_now = bus_en_ff & scl_fall & ~start_det & ~stop_det & (st_ff == S_WDATA) &
                  (cnt_ff == BYTE_BITS) & (idx_ff == IDX_CTRL);
  // Protective events in fault byte order
  assign fault_set = {otsd, dc_det, ov, uv, ocsd, diag_short, 2'h0};
  // Latched faults, cleared when read, new events win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= 8'h00;
    end else begin
      fault_ff <= ((load_now && idx_ff == IDX_FAULT) ? 8'h00 : fault_ff) | fault_set;
    end
  end
  // Live status and diagnostics, play bit down to short to supply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= {run_ff, mute_sy_ff[1], diag_busy, protect,
                    shorted_load, open_load, short_gnd, short_pvdd};
    end
  end
  // Control byte: gain, limiter, switching frequency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_now) begin
      ctrl_ff <= sh_ff;
    end
  end
  // ************************************************
  // Serial protocol engine
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= S_IDLE;
      ack_next_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      idx_ff <= 8'h00;
      mack_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (!bus_en_ff) begin
      st_ff <= S_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else if (start_det) begin
      st_ff <= S_ADDR;
      cnt_ff <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end else if (stop_det) begin
      st_ff <= S_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else begin
      case (st_ff)
        S_ADDR, S_INDEX, S_WDATA: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BYTE_BITS) begin
            cnt_ff <= 4'h0;
            st_ff <= S_ACK;
            sda_oe_n_ff <= 1'b0;
            if (st_ff == S_ADDR) begin
              if (sh_ff[7:1] != TARGET_ADDR) begin
                st_ff <= S_IDLE;
                sda_oe_n_ff <= 1'b1;
              end
              ack_next_ff <= sh_ff[0] ? S_RDATA : S_INDEX;
            end else if (st_ff == S_INDEX) begin
              idx_ff <= sh_ff;
              ack_next_ff <= S_WDATA;
            end else begin
              ack_next_ff <= S_WDATA;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            st_ff <= ack_next_ff;
            cnt_ff <= 4'h0;
            tx_ff <= {rd_val[6:0], 1'b0};
            sda_oe_n_ff <= (ack_next_ff == S_RDATA) ? rd_val[7] : 1'b1;
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (cnt_ff == BYTE_BITS) begin
              sda_oe_n_ff <= 1'b1;
              st_ff <= S_RACK;
            end else begin
              sda_oe_n_ff <= tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b0};
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_ff <= ~sda_s;
            if (!sda_s) begin
              idx_ff <= idx_ff + 8'h01;
            end
          end else if (scl_fall) begin
            cnt_ff <= 4'h0;
            if (mack_ff) begin
              st_ff <= S_RDATA;
              sda_oe_n_ff <= rd_val[7];
              tx_ff <= {rd_val[6:0], 1'b0};
            end else begin
              st_ff <= S_IDLE;
            end
          end
        end
        default: begin
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end
  // ************************************************
  // Outputs
  // ************************************************
  assign bus.d_sda_oe_n = sda_oe_n_ff;
  assign bus.d_fault_oe_n = fault_oe_n_ff;
  assign gain_code = ctrl_ff[CTRL_GAIN_LSB +: 2];
  assign limiter_code = ctrl_ff[CTRL_LIM_LSB +: 3];
  assign freq_sel = ctrl_ff[CTRL_FREQ];
  assign out_run = run_ff;
  assign out_hiz = hiz_ff;
endmodule

/* File: core/amp_pkg.sv */
package amp_pkg;
  // ************************************************
  // Bus identity and register indices
  // ************************************************
  localparam logic [6:0] TARGET_ADDR = 7'h6C;
  localparam logic [7:0] IDX_FAULT = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_CTRL = 8'h03;
  localparam logic [7:0] CTRL_RESET = 8'h78;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Fault byte bit positions
  localparam int FLT_DIAG = 2;
  localparam int FLT_OC = 3;
  localparam int FLT_UV = 4;
  localparam int FLT_OV = 5;
  localparam int FLT_DC = 6;
  localparam int FLT_OT = 7;
  // Status byte bit positions
  localparam int STS_SHORT_PVDD = 0;
  localparam int STS_SHORT_GND = 1;
  localparam int STS_OPEN = 2;
  localparam int STS_SHORTED = 3;
  localparam int STS_FAULT = 4;
  localparam int STS_DIAG = 5;
  localparam int STS_MUTE = 6;
  localparam int STS_PLAY = 7;
  // Control byte fields
  localparam int CTRL_FREQ = 0;
  localparam int CTRL_LIM_LSB = 3;
  localparam int CTRL_GAIN_LSB = 6;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAKE_TIME_NS = 1000000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_TIME_NS = 2500;
  localparam int QTR_CYCLES = (BIT_TIME_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // ************************************************
  // Controller register map (APB)
  // ************************************************
  localparam logic [7:0] A_PINS = 8'h00;
  localparam logic [7:0] A_XFER = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_FLTPIN = 8'h0C;
  localparam int XF_DATA_LSB = 8;
  localparam int XF_RNW = 16;
  localparam int ST_NACK = 1;
  localparam int ST_RX_LSB = 8;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_INDEX, S_WDATA, S_ACK, S_RDATA, S_RACK} dev_state_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mst_state_t;
endpackage

/* File: core/amp_if.sv */
`timescale 1ns/1ns
interface amp_if;
  logic scl;
  logic sda;
  logic fault_n;
  logic standby_n;
  logic mute;
  logic m_scl_oe_n;
  logic m_sda_oe_n;
  logic d_sda_oe_n;
  logic d_fault_oe_n;

  // Wired-AND lines with pull-ups
  assign scl = m_scl_oe_n;
  assign sda = m_sda_oe_n & d_sda_oe_n;
  assign fault_n = d_fault_oe_n;

  modport dev (input scl, sda, standby_n, mute, output d_sda_oe_n, d_fault_oe_n);
  modport host (input scl, sda, fault_n, output m_scl_oe_n, m_sda_oe_n, standby_n, mute);
endinterface

/* File: core/amp_i2c_master.sv */
`timescale 1ns/1ns
module amp_i2c_master
  import amp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  amp_if.host bus
);
  // ************************************************
  // Synchronisers and bit-rate divider
  // ************************************************
  logic [1:0] sda_sy_ff;
  logic [1:0] flt_sy_ff;
  logic [7:0] qcnt_ff;
  logic tick;
  mst_state_t st_ff;

  // Two flops per sampled pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sy_ff <= 2'h3;
      flt_sy_ff <= 2'h3;
    end else begin
      sda_sy_ff <= {sda_sy_ff[0], bus.sda};
      flt_sy_ff <= {flt_sy_ff[0], bus.fault_n};
    end
  end

  // Quarter-bit enable pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_ff <= 8'h00;
    end else if (st_ff == M_IDLE || qcnt_ff == 8'(QTR_CYCLES - 1)) begin
      qcnt_ff <= 8'h00;
    end else begin
      qcnt_ff <= qcnt_ff + 8'h01;
    end
  end

  assign tick = (st_ff != M_IDLE) && (qcnt_ff == 8'(QTR_CYCLES - 1));

  // ************************************************
  // APB slave
  // ************************************************
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [1:0] pins_ff;
  logic busy_ff;
  logic nack_ff;
  logic [7:0] rx_ff;
  logic apb_wr;

  assign apb_wr = psel & penable & pready_ff & pwrite;

  // One wait-free access phase per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      if (psel && !penable) begin
        if (paddr == A_PINS) begin
          prdata_ff <= {30'h0, pins_ff};
        end else if (paddr == A_XFER) begin
          prdata_ff <= 32'h0;
        end else if (paddr == A_STAT) begin
          prdata_ff <= {16'h0, rx_ff, 6'h0, nack_ff, busy_ff};
        end else if (paddr == A_FLTPIN) begin
          prdata_ff <= {31'h0, flt_sy_ff[1]};
        end else begin
          pslverr_ff <= 1'b1;
        end
      end
    end
  end

  // Standby and mute pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_ff <= 2'h0;
    end else if (apb_wr && paddr == A_PINS) begin
      pins_ff <= pwdata[1:0];
    end
  end

  // ************************************************
  // Transfer engine
  // ************************************************
  logic [1:0] q_ff;
  logic [1:0] byte_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic [7:0] idx_ff;
  logic [7:0] data_ff;
  logic rnw_ff;
  logic scl_oe_n_ff;
  logic sda_oe_n_ff;
  logic rx_byte;
  logic last_byte;

  // Byte sent in each slot of a transfer
  function automatic logic [7:0] tx_byte(input logic [1:0] b, input logic rnw,
                                         input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = 8'hFF;
    if (b == 2'h0) begin
      v = {TARGET_ADDR, 1'b0};
    end else if (b == 2'h1) begin
      v = idx;
    end else if (b == 2'h2) begin
      v = rnw ? {TARGET_ADDR, 1'b1} : d;
    end
    return v;
  endfunction

  assign rx_byte = rnw_ff & (byte_ff == 2'h3);
  assign last_byte = rx_byte | (~rnw_ff & (byte_ff == 2'h2));

  // Start, bytes with acknowledge, repeated start, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= M_IDLE;
      q_ff <= 2'h0;
      byte_ff <= 2'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'hFF;
      idx_ff <= 8'h00;
      data_ff <= 8'h00;
      rnw_ff <= 1'b0;
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      rx_ff <= 8'h00;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
    end else if (st_ff == M_IDLE) begin
      if (apb_wr && paddr == A_XFER) begin
        idx_ff <= pwdata[7:0];
        data_ff <= pwdata[XF_DATA_LSB +: 8];
        rnw_ff <= pwdata[XF_RNW];
        busy_ff <= 1'b1;
        nack_ff <= 1'b0;
        byte_ff <= 2'h0;
        q_ff <= 2'h0;
        st_ff <= M_START;
      end
    end else if (tick) begin
      q_ff <= q_ff + 2'h1;
      case (st_ff)
        M_START: begin
          if (q_ff == 2'h0) begin
            sda_oe_n_ff <= 1'b1;
          end else if (q_ff == 2'h1) begin
            scl_oe_n_ff <= 1'b1;
          end else if (q_ff == 2'h2) begin
            sda_oe_n_ff <= 1'b0;
          end else begin
            scl_oe_n_ff <= 1'b0;
            bit_ff <= 4'h0;
            sh_ff <= tx_byte(byte_ff, rnw_ff, idx_ff, data_ff);
            st_ff <= M_BIT;
          end
        end
        M_BIT: begin
          if (q_ff == 2'h0) begin
            sda_oe_n_ff <= (bit_ff == BYTE_BITS) ? 1'b1 : sh_ff[7];
          end else if (q_ff == 2'h1) begin
            scl_oe_n_ff <= 1'b1;
          end else if (q_ff == 2'h2) begin
            if (bit_ff != BYTE_BITS) begin
              rx_ff <= rx_byte ? {rx_ff[6:0], sda_sy_ff[1]} : rx_ff;
              sh_ff <= {sh_ff[6:0], 1'b1};
            end else if (!rx_byte && sda_sy_ff[1]) begin
              nack_ff <= 1'b1;
            end
          end else begin
            scl_oe_n_ff <= 1'b0;
            if (bit_ff != BYTE_BITS) begin
              bit_ff <= bit_ff + 4'h1;
            end else if (nack_ff || last_byte) begin
              st_ff <= M_STOP;
            end else if (rnw_ff && byte_ff == 2'h1) begin
              byte_ff <= 2'h2;
              st_ff <= M_START;
            end else begin
              bit_ff <= 4'h0;
              byte_ff <= byte_ff + 2'h1;
              sh_ff <= tx_byte(byte_ff + 2'h1, rnw_ff, idx_ff, data_ff);
            end
          end
        end
        default: begin
          if (q_ff == 2'h0) begin
            sda_oe_n_ff <= 1'b0;
          end else if (q_ff == 2'h1) begin
            scl_oe_n_ff <= 1'b1;
          end else if (q_ff == 2'h2) begin
            sda_oe_n_ff <= 1'b1;
          end else begin
            busy_ff <= 1'b0;
            st_ff <= M_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign bus.m_scl_oe_n = scl_oe_n_ff;
  assign bus.m_sda_oe_n = sda_oe_n_ff;
  assign bus.standby_n = pins_ff[0];
  assign bus.mute = pins_ff[1];
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
endmodule

/* File: tb/amp_props.sv */
`timescale 1ns/1ns
module amp_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic standby_n,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_oe_n,
  input wire logic d_fault_oe_n
);
  // ************************************************
  // Wire rules
  // ************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Quiet device around standby and wake-up
  a_wake_quiet: assert property ($rose(standby_n) |-> d_sda_oe_n [*8])
    else $error("device drove data right after wake");
  a_standby_data: assert property (!standby_n [*6] |-> d_sda_oe_n)
    else $error("data driven in standby");
  a_standby_fault: assert property (!standby_n [*6] |-> d_fault_oe_n)
    else $error("fault pin driven in standby");
  // Device data changes only while clock low
  a_dev_change_low: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("device data moved with clock high");
  a_hold_high: assert property ($rose(scl) && !d_sda_oe_n |-> !d_sda_oe_n [*8])
    else $error("device low not held over clock high");
  // Master start keeps clock high afterwards
  a_start_hold: assert property ($fell(m_sda_oe_n) && scl |-> scl [*8])
    else $error("clock fell too soon after start");
  a_scl_high: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_bus_share: assert property (scl && !d_sda_oe_n |-> m_sda_oe_n)
    else $error("master drove data while device sends");
endmodule

/* File: tb/amp_i2c_slave_control_tb.sv */
`timescale 1ns/1ns
module amp_i2c_slave_control_tb;
  import amp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic freq_sel, out_run, out_hiz;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, s;
  logic [10:0] cond;
  logic [1:0] gain_code;
  logic [2:0] limiter_code;
  int n_errors, checks_done, pos;

  amp_if amp_if_i ();
  amp_i2c_master amp_i2c_master_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(amp_if_i.host));
  amp_i2c_slave #(.WAKE_CYC(2000)) amp_i2c_slave_i (.pclk(pclk), .presetn(presetn),
    .bus(amp_if_i.dev), .ocsd(cond[0]), .uv(cond[1]), .ov(cond[2]), .dc_det(cond[3]),
    .otsd(cond[4]), .diag_short(cond[5]), .short_pvdd(cond[6]), .short_gnd(cond[7]),
    .open_load(cond[8]), .shorted_load(cond[9]), .diag_busy(cond[10]),
    .gain_code(gain_code), .limiter_code(limiter_code), .freq_sel(freq_sel),
    .out_run(out_run), .out_hiz(out_hiz));
  amp_props amp_props_i (.pclk(pclk), .presetn(presetn), .scl(amp_if_i.scl),
    .standby_n(amp_if_i.standby_n), .m_sda_oe_n(amp_if_i.m_sda_oe_n),
    .d_sda_oe_n(amp_if_i.d_sda_oe_n), .d_fault_oe_n(amp_if_i.d_fault_oe_n));

  // ************************************************
  // Helpers
  // ************************************************
  task automatic final_report;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("Error t=%0t ready timeout got=%h exp=%h", $time, pready, 1'b1);
      final_report();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Start a link transfer and poll until not busy
  task automatic xfer(input logic rd, input logic [7:0] i, input logic [7:0] d,
                      output logic [31:0] q);
    int n;
    apb(1'b1, A_XFER, {15'h0000, rd, d, i}, q);
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h00000000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 3000);
    if (q[0] !== 1'b0) begin
      n_errors++;
      $display("Error t=%0t busy timeout got=%h exp=%h", $time, q[0], 1'b0);
      final_report();
    end
  endtask

  // Clock source
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    cond = 11'h000;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_PINS, 32'h00000000, s);
    chk(s, 32'h00000000);
    apb(1'b0, 8'h10, 32'h00000000, s);
    chk(err, 1'b1);
    // Bus refused until wake-up time passed
    apb(1'b1, A_PINS, 32'h00000001, s);
    xfer(1'b1, IDX_CTRL, 8'h00, s);
    chk(s[ST_NACK], 1'b1);
    chk({amp_if_i.scl, amp_if_i.sda}, 2'b11);
    repeat (2000) @(posedge pclk);
    xfer(1'b1, IDX_CTRL, 8'h00, s);
    chk(s[15:8], CTRL_RESET);
    // Every gain code written, fields reach the outputs
    for (int g = 0; g < 4; g++) begin
      xfer(1'b0, IDX_CTRL, {g[1:0], 6'h09}, s);
      chk(s[ST_NACK], 1'b0);
      chk({gain_code, limiter_code, freq_sel}, {g[1:0], 4'h3});
    end
    xfer(1'b1, IDX_CTRL, 8'h00, s);
    chk(s[15:8], 8'hC9);
    // Each protective cause drives the pin and is readable
    for (int i = 0; i < 6; i++) begin
      pos = (i == 5) ? FLT_DIAG : i + 3;
      cond[i] <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, A_FLTPIN, 32'h00000000, s);
      chk(s[0], 1'b0);
      xfer(1'b1, IDX_FAULT, 8'h00, s);
      chk(s[ST_RX_LSB + pos], 1'b1);
      cond[i] <= 1'b0;
    end
    // Mute with diagnostics present
    cond[8] <= 1'b1;
    cond[6] <= 1'b1;
    cond[10] <= 1'b1;
    apb(1'b1, A_PINS, 32'h00000003, s);
    repeat (4) @(posedge pclk);
    chk({out_run, out_hiz}, 2'b01);
    xfer(1'b1, IDX_STATUS, 8'h00, s);
    chk(s[15:8], 8'h65);
    cond <= 11'h000;
    apb(1'b1, A_PINS, 32'h00000001, s);
    repeat (10) @(posedge pclk);
    chk(out_run, 1'b1);
    // Standby stops the bus and frees the fault pin
    apb(1'b1, A_PINS, 32'h00000000, s);
    cond[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, A_FLTPIN, 32'h00000000, s);
    chk(s[0], 1'b1);
    chk(out_hiz, 1'b1);
    xfer(1'b1, IDX_CTRL, 8'h00, s);
    chk(s[ST_NACK], 1'b1);
    final_report();
  end
endmodule
